/* File: logic/aab_pkg.sv */
/*
 * Constants for the converter accumulator, burst and power-sequencing control:
 * register offsets, field positions, reset values, burst state encoding and timing.
 * Assumes a core clock of 50 MHz and an 8-bit special-function register port
 * in which the page selects between the two registers that share an address.
 */
package aab_pkg;

    localparam logic [7:0] ACC_CFG_ADDR    = 8'hba;
    localparam logic [7:0] PWR_TIME_ADDR   = 8'hba;
    localparam logic [7:0] RES_HIGH_ADDR   = 8'hbe;
    localparam logic [7:0] RES_LOW_ADDR    = 8'hbd;
    localparam logic [3:0] ACC_CFG_PAGE    = 4'h0;
    localparam logic [3:0] PWR_TIME_PAGE   = 4'hf;
    localparam logic [3:0] RES_PAGE        = 4'h0;

    localparam int TWELVE_BIT_POS   = 7;
    localparam int ACCUM_EN_POS     = 6;
    localparam int SJST_LSB         = 3;
    localparam int RPT_LSB          = 0;
    localparam int LPM_POS          = 7;
    localparam int PWR_SEL_LSB      = 0;

    localparam logic [7:0] ACC_CFG_RESET  = 8'h00;
    localparam logic [7:0] PWR_TIME_RESET = 8'h0f;

    localparam logic [2:0] SJST_LEFT      = 3'h4;

    localparam int CLK_HZ           = 50_000_000;
    localparam int PWR_STEP_NS      = 400;
    // Least time, rounded up to whole cycles
    localparam int PWR_STEP_CYC     = (PWR_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [3:0] {
        AAB_IDLE  = 4'b0001,
        AAB_POWUP = 4'b0010,
        AAB_CONV  = 4'b0100,
        AAB_WAIT  = 4'b1000
    } aab_state_e;

endpackage

/* File: logic/aab_powerup_timer.sv */
/*
 * Power-up delay timer: counts (selection plus one) steps of the step length.
 * Assumes start is a one-cycle pulse; done pulses once when the delay expires.
 */
`timescale 1ns/10ps
`default_nettype none
module aab_powerup_timer #(
    parameter int STEP_CYC = aab_pkg::PWR_STEP_CYC
) (
    input  wire logic       core_clk_i, // System clock
    input  wire logic       rst_b_i,    // Asynchronous reset, active low
    input  wire logic       start_i,    // Begin timing
    input  wire logic [3:0] sel_i,      // Delay selection
    output logic            done_o      // Delay elapsed pulse
);
    if (STEP_CYC < 1 || STEP_CYC > 255) begin
        $error("aab_powerup_timer: STEP_CYC out of range");
    end

    logic [7:0] cyc_q;
    logic [4:0] steps_q;
    logic       run_q;
    wire        step_end = (cyc_q == 8'(STEP_CYC - 1));
    wire        last     = step_end && (steps_q == 5'h00);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cyc_q   <= 8'h00;
            steps_q <= 5'h00;
            run_q   <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= run_q && last;
            if (start_i) begin
                run_q   <= 1'b1;
                cyc_q   <= 8'h00;
                steps_q <= {1'b0, sel_i};
            end else if (run_q) begin
                cyc_q <= step_end ? 8'h00 : cyc_q + 8'h01;
                if (step_end) begin
                    steps_q <= steps_q - 5'h01;
                end
                if (last) begin
                    run_q <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/aab_result_format.sv */
/*
 * Result formatter: applies the shift/justify selection to the 16-bit
 * accumulator for reads. Purely combinational; the caller registers it.
 */
`timescale 1ns/10ps
`default_nettype none
module aab_result_format (
    input  wire logic [15:0] acc_i,      // Raw accumulator
    input  wire logic [2:0]  sjst_i,     // Shift/justify selection
    input  wire logic [11:0] conv_mask_i,// Width mask of one conversion
    output logic      [15:0] fmt_o       // Formatted value
);
    wire [15:0] left_j = (conv_mask_i[11]) ? {acc_i[11:0], 4'h0} : {acc_i[9:0], 6'h00};

    // right shifts bring in zeros at the top
    assign fmt_o = (sjst_i == 3'h0) ? acc_i :
                   (sjst_i == 3'h1) ? (acc_i >> 1) :
                   (sjst_i == 3'h2) ? (acc_i >> 2) :
                   (sjst_i == 3'h3) ? (acc_i >> 3) :
                   (sjst_i == aab_pkg::SJST_LEFT) ? left_j : acc_i;
endmodule
`default_nettype wire

/* File: logic/aab_ctrl.sv */
/*
 * Accumulator, burst sequencing and power control around the converter core.
 * Registers are reached over the 8-bit special-function port (page, address,
 * write strobe, read data). Assumes the analog core signals conv_done_i with
 * its data one cycle per finished conversion and starts on conv_start_o.
 */
`timescale 1ns/10ps
`default_nettype none
module aab_ctrl #(
    parameter int STEP_CYC = aab_pkg::PWR_STEP_CYC
) (
    input  wire logic        core_clk_i,    // System clock, 50 MHz
    input  wire logic        rst_b_i,       // Asynchronous reset, active low
    input  wire logic [3:0]  sfr_page_i,    // Register page
    input  wire logic [7:0]  sfr_addr_i,    // Register address
    input  wire logic        sfr_wr_i,      // Write strobe
    input  wire logic        sfr_rd_i,      // Read strobe
    input  wire logic [7:0]  sfr_wdata_i,   // Write data
    output logic      [7:0]  sfr_rdata_o,   // Read data, valid cycle after strobe
    input  wire logic        burst_mode_en_i,    // Burst mode enable
    input  wire logic        converter_enable_i, // Converter enable
    input  wire logic        soc_i,              // Start-of-conversion pulse
    input  wire logic        conv_done_i,        // Conversion finished pulse
    input  wire logic [11:0] conv_data_i,        // Conversion result
    output logic             conv_start_o,       // Start one conversion
    output logic             conv_first_o,       // Start is first of burst
    output logic             power_on_o,         // Converter powered
    output logic             twelve_bit_o,       // Twelve-bit mode
    output logic             low_power_o,        // Low-power operation
    output logic             burst_done_o        // Burst complete pulse
);
    // The power-up timer counts each step in an 8-bit counter
    if (STEP_CYC < 1 || STEP_CYC > 255) begin
        $error("aab_ctrl: STEP_CYC out of range");
    end

    logic [7:0]  acc_cfg_q;
    logic [7:0]  pwr_q;
    logic [15:0] acc_q;
    logic [15:0] acc_d;
    logic [6:0]  left_q;
    logic [6:0]  left_d;
    aab_pkg::aab_state_e state_q;
    aab_pkg::aab_state_e state_d;
    logic        timer_start;
    logic        timer_done;
    logic [15:0] fmt;
    logic [7:0]  rdata_d;

    // Register decode
    wire acc_sel  = (sfr_page_i == aab_pkg::ACC_CFG_PAGE)  && (sfr_addr_i == aab_pkg::ACC_CFG_ADDR);
    wire pwr_sel  = (sfr_page_i == aab_pkg::PWR_TIME_PAGE) && (sfr_addr_i == aab_pkg::PWR_TIME_ADDR);
    wire hi_sel   = (sfr_page_i == aab_pkg::RES_PAGE)      && (sfr_addr_i == aab_pkg::RES_HIGH_ADDR);
    wire lo_sel   = (sfr_page_i == aab_pkg::RES_PAGE)      && (sfr_addr_i == aab_pkg::RES_LOW_ADDR);
    wire acc_wr   = sfr_wr_i && acc_sel;
    wire pwr_wr   = sfr_wr_i && pwr_sel;
    wire hi_wr    = sfr_wr_i && hi_sel;
    wire lo_wr    = sfr_wr_i && lo_sel;

    wire       twelve_en = acc_cfg_q[aab_pkg::TWELVE_BIT_POS];
    wire       accum_en  = acc_cfg_q[aab_pkg::ACCUM_EN_POS];
    wire [2:0] sjst      = acc_cfg_q[aab_pkg::SJST_LSB +: 3];
    wire [2:0] rpt       = acc_cfg_q[aab_pkg::RPT_LSB +: 3];
    wire [3:0] pwr_dly   = pwr_q[aab_pkg::PWR_SEL_LSB +: 4];

    wire [6:0] rpt_count = (rpt == 3'h1) ? 7'd4  :
                           (rpt == 3'h2) ? 7'd8  :
                           (rpt == 3'h3) ? 7'd16 :
                           (rpt == 3'h4) ? 7'd32 :
                           (rpt == 3'h5) ? 7'd64 : 7'd1;

    wire [11:0] conv_mask = twelve_en ? 12'hfff : 12'h3ff;
    wire [15:0] sample    = {4'h0, conv_data_i & conv_mask};
    wire        in_burst  = (state_q != aab_pkg::AAB_IDLE);
    wire        burst_go  = burst_mode_en_i && soc_i && (state_q == aab_pkg::AAB_IDLE);

    aab_powerup_timer #(
        .STEP_CYC (STEP_CYC)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .start_i    (timer_start),
        .sel_i      (pwr_dly),
        .done_o     (timer_done)
    );

    aab_result_format u_fmt (
        .acc_i       (acc_q),
        .sjst_i      (sjst),
        .conv_mask_i (conv_mask),
        .fmt_o       (fmt)
    );

    // delay only when the converter was left unpowered
    assign timer_start = burst_go && !converter_enable_i;

    // Burst sequencer
    always_comb begin
        state_d = state_q;
        left_d  = left_q;
        case (state_q)
            aab_pkg::AAB_IDLE: begin
                if (burst_go) begin
                    left_d  = rpt_count;
                    state_d = converter_enable_i ? aab_pkg::AAB_CONV : aab_pkg::AAB_POWUP;
                end
            end
            aab_pkg::AAB_POWUP: begin
                if (timer_done) begin
                    state_d = aab_pkg::AAB_CONV;
                end
            end
            aab_pkg::AAB_CONV: begin
                state_d = aab_pkg::AAB_WAIT;
            end
            aab_pkg::AAB_WAIT: begin
                if (conv_done_i) begin
                    left_d  = left_q - 7'd1;
                    state_d = (left_q == 7'd1) ? aab_pkg::AAB_IDLE : aab_pkg::AAB_CONV;
                end
            end
            default: begin
                state_d = aab_pkg::AAB_IDLE;
            end
        endcase
    end

    // Accumulator update; a conversion result overrides a byte write, except in accumulate mode outside a burst with burst mode off, where it adds to it
    always_comb begin
        acc_d = acc_q;
        if (hi_wr) begin
            acc_d[15:8] = sfr_wdata_i;
        end
        if (lo_wr) begin
            acc_d[7:0] = sfr_wdata_i;
        end
        if (burst_go) begin
            acc_d = 16'h0000;
        end else if (conv_done_i && in_burst) begin
            acc_d = acc_q + sample;
        end else if (conv_done_i && !burst_mode_en_i) begin
            acc_d = accum_en ? acc_d + sample : sample;
        end
    end

    // write-only and unused bits read zero
    assign rdata_d = acc_sel ? {acc_cfg_q[7], 1'b0, acc_cfg_q[5:0]} :
                     pwr_sel ? {pwr_q[7], 3'h0, pwr_q[3:0]} :
                     hi_sel  ? fmt[15:8] :
                     lo_sel  ? fmt[7:0]  : 8'h00;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_cfg_q <= aab_pkg::ACC_CFG_RESET;
            pwr_q     <= aab_pkg::PWR_TIME_RESET;
        end else begin
            if (acc_wr) begin
                acc_cfg_q <= sfr_wdata_i;
            end
            if (pwr_wr) begin
                pwr_q <= {sfr_wdata_i[7], 3'h0, sfr_wdata_i[3:0]};
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= aab_pkg::AAB_IDLE;
            left_q  <= 7'd0;
            acc_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            left_q  <= left_d;
            acc_q   <= acc_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o  <= 8'h00;
            conv_start_o <= 1'b0;
            conv_first_o <= 1'b0;
            power_on_o   <= 1'b0;
            twelve_bit_o <= 1'b0;
            low_power_o  <= 1'b0;
            burst_done_o <= 1'b0;
        end else begin
            sfr_rdata_o  <= sfr_rd_i ? rdata_d : 8'h00;
            // first start of a burst carries no extra track delay
            conv_start_o <= (state_d == aab_pkg::AAB_CONV) || (!burst_mode_en_i && soc_i);
            conv_first_o <= (state_d == aab_pkg::AAB_CONV) && (left_d == rpt_count)
                            && (state_q != aab_pkg::AAB_WAIT);
            // power follows enable, or burst activity
            power_on_o   <= converter_enable_i || (burst_mode_en_i && (state_d != aab_pkg::AAB_IDLE));
            twelve_bit_o <= twelve_en;
            low_power_o  <= pwr_q[aab_pkg::LPM_POS];
            burst_done_o <= (state_q == aab_pkg::AAB_WAIT) && conv_done_i && (left_q == 7'd1);
        end
    end
endmodule
`default_nettype wire

/* File: verification/aab_ctrl_sva.sv */
/* Port checker for the converter accumulator and burst control.
   Assumes binding to aab_ctrl; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module aab_ctrl_sva #(
    parameter int STEP_CYC = aab_pkg::PWR_STEP_CYC
) (
    input wire logic        core_clk_i,         // clock
    input wire logic        rst_b_i,            // reset
    input wire logic [3:0]  sfr_page_i,         // page
    input wire logic [7:0]  sfr_addr_i,         // address
    input wire logic        sfr_wr_i,           // write
    input wire logic        sfr_rd_i,           // read
    input wire logic [7:0]  sfr_wdata_i,        // write data
    input wire logic [7:0]  sfr_rdata_o,        // read data
    input wire logic        burst_mode_en_i,    // burst
    input wire logic        converter_enable_i, // enable
    input wire logic        soc_i,              // start
    input wire logic        conv_done_i,        // done
    input wire logic [11:0] conv_data_i,        // sample
    input wire logic        conv_start_o,       // convert
    input wire logic        conv_first_o,       // first
    input wire logic        power_on_o,         // power
    input wire logic        twelve_bit_o,       // 12-bit
    input wire logic        low_power_o,        // low power
    input wire logic        burst_done_o        // burst end
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_cfg_bit6_zero: assert property ($past(sfr_rd_i) && $past(sfr_page_i) == 4'h0 &&
        $past(sfr_addr_i) == 8'hba |-> !sfr_rdata_o[6]) else $error("bit 6 read as one");
    a_pwr_unused_zero: assert property ($past(sfr_rd_i) && $past(sfr_page_i) == 4'hf &&
        $past(sfr_addr_i) == 8'hba |-> sfr_rdata_o[6:4] == 3'h0) else $error("bits 6:4 set");
    a_twelve_mirror: assert property (sfr_wr_i && sfr_page_i == 4'h0 && sfr_addr_i == 8'hba
        |=> ##1 twelve_bit_o == $past(sfr_wdata_i[7], 2)) else $error("twelve bit wrong");
    a_lowpow_mirror: assert property (sfr_wr_i && sfr_page_i == 4'hf && sfr_addr_i == 8'hba
        |=> ##1 low_power_o == $past(sfr_wdata_i[7], 2)) else $error("low power wrong");
    a_power_follows: assert property (!burst_mode_en_i && $past(!burst_mode_en_i) &&
        $past(rst_b_i) |-> power_on_o == $past(converter_enable_i)) else $error("power wrong");
    a_fast_first: assert property (soc_i && burst_mode_en_i && converter_enable_i
        |=> conv_start_o && conv_first_o) else $error("fast start missing");
    a_slow_start: assert property (soc_i && burst_mode_en_i && !converter_enable_i
        |=> !conv_start_o [*2] ##[1:1000] conv_start_o) else $error("slow start wrong");
    a_done_after_conv: assert property (burst_done_o |-> $past(conv_done_i) &&
        !conv_start_o) else $error("burst end without conversion");
    a_sleep_after: assert property (burst_done_o && !converter_enable_i
        |-> ##[1:3] !power_on_o) else $error("no sleep after burst");
endmodule
bind aab_ctrl aab_ctrl_sva #(.STEP_CYC(STEP_CYC)) u_sva (.core_clk_i, .rst_b_i, .sfr_page_i,
    .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .burst_mode_en_i,
    .converter_enable_i, .soc_i, .conv_done_i, .conv_data_i, .conv_start_o, .conv_first_o,
    .power_on_o, .twelve_bit_o, .low_power_o, .burst_done_o);
`default_nettype wire

/* File: verification/tb_top.sv */
/* Self-checking bench for aab_ctrl, which it drives directly,
   standing in for the software and the analog converter core. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [2:0] rpt; logic [2:0] sj; logic [11:0] smp;
        logic [6:0] n; logic [15:0] exp;} aab_row_s;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    logic burst_mode_en_i = 1'b0, converter_enable_i = 1'b0, soc_i = 1'b0;
    logic conv_done_i = 1'b0, conv_start_o, conv_first_o, power_on_o;
    logic twelve_bit_o, low_power_o, burst_done_o;
    logic [3:0]  sfr_page_i = 4'h0;
    logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
    logic [11:0] conv_data_i = 12'h000, smp = 12'h000;
    int bad_count = 0, checks = 0, ncyc = 0, nstart = 0, nfirst = 0;
    aab_row_s rows [7] = '{'{3'h0, 3'h0, 12'habc, 7'd1, 16'h0abc},
        '{3'h1, 3'h1, 12'hfff, 7'd4, 16'h1ffe}, '{3'h2, 3'h2, 12'h123, 7'd8, 16'h0246},
        '{3'h3, 3'h3, 12'h800, 7'd16, 16'h1000}, '{3'h4, 3'h0, 12'h7ff, 7'd32, 16'hffe0},
        '{3'h5, 3'h0, 12'h3ff, 7'd64, 16'hffc0}, '{3'h0, 3'h4, 12'h5a5, 7'd1, 16'h5a50}};

    aab_ctrl #(.STEP_CYC(2)) uut (.core_clk_i, .rst_b_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .burst_mode_en_i, .converter_enable_i, .soc_i,
        .conv_done_i, .conv_data_i, .conv_start_o, .conv_first_o, .power_on_o, .twelve_bit_o,
        .low_power_o, .burst_done_o);

    always #10 core_clk_i = ~core_clk_i;

    task automatic summarize;
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        ncyc++;
        if (ncyc == 20000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] d);
        @(negedge core_clk_i);
        sfr_page_i = pg;
        sfr_addr_i = ad;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge core_clk_i);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [3:0] pg, input logic [7:0] ad, output logic [7:0] v);
        @(negedge core_clk_i);
        sfr_page_i = pg;
        sfr_addr_i = ad;
        sfr_rd_i = 1'b1;
        @(negedge core_clk_i);
        sfr_rd_i = 1'b0;
        v = sfr_rdata_o;
    endtask

    task automatic chk_res(input logic [15:0] exp);
        logic [7:0] h;
        logic [7:0] l;
        rd(4'h0, 8'hbe, h);
        rd(4'h0, 8'hbd, l);
        cmp({h, l}, exp);
    endtask

    task automatic start_conv;
        @(negedge core_clk_i);
        soc_i = 1'b1;
        @(negedge core_clk_i);
        soc_i = 1'b0;
    endtask

    task automatic wait_done;
        int k;
        for (k = 0; k < 3000 && burst_done_o !== 1'b1; k++)
            @(negedge core_clk_i);
        cmp(16'(k < 3000), 16'h1);
    endtask

    // Converter core stand-in: answers each start two cycles later; a start that
    // follows a done directly is seen in the same falling edge that drops done
    initial forever begin
        @(negedge core_clk_i);
        while (conv_start_o === 1'b1) begin
            nstart++;
            if (conv_first_o === 1'b1)
                nfirst++;
            repeat (2) @(negedge core_clk_i);
            conv_data_i = smp;
            conv_done_i = 1'b1;
            @(negedge core_clk_i);
            conv_done_i = 1'b0;
            conv_data_i = ~smp;
        end
    end

    initial begin
        logic [7:0] v;
        int k;
        repeat (3) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        rd(4'h0, 8'hba, v);
        cmp(v, 8'h00);
        rd(4'hf, 8'hba, v);
        cmp(v, 8'h0f);
        rd(4'h0, 8'h00, v);
        cmp(v, 8'h00);
        wr(4'h0, 8'hba, 8'hd8);
        rd(4'h0, 8'hba, v);
        cmp(v, 8'h98);
        cmp(twelve_bit_o, 1'b1);
        wr(4'hf, 8'hba, 8'hf5);
        rd(4'hf, 8'hba, v);
        cmp(v, 8'h85);
        cmp(low_power_o, 1'b1);
        converter_enable_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        cmp(power_on_o, 1'b1);
        converter_enable_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        cmp(power_on_o, 1'b0);
        converter_enable_i = 1'b1;
        wr(4'h0, 8'hba, 8'hc0);
        wr(4'h0, 8'hbe, 8'h00);
        wr(4'h0, 8'hbd, 8'h00);
        smp = 12'h100;
        repeat (2) begin
            start_conv();
            repeat (8) @(negedge core_clk_i);
        end
        chk_res(16'h0200);
        wr(4'h0, 8'hba, 8'h80);
        smp = 12'h321;
        start_conv();
        repeat (8) @(negedge core_clk_i);
        chk_res(16'h0321);
        burst_mode_en_i = 1'b1;
        foreach (rows[i]) begin
            wr(4'h0, 8'hba, {2'b10, rows[i].sj, rows[i].rpt});
            smp = rows[i].smp;
            nstart = 0;
            nfirst = 0;
            start_conv();
            wait_done();
            repeat (4) @(negedge core_clk_i);
            cmp(16'(nstart), 16'(rows[i].n));
            cmp(16'(nfirst), 16'h1);
            cmp(power_on_o, 1'b1);
            chk_res(rows[i].exp);
        end
        converter_enable_i = 1'b0;
        wr(4'h0, 8'hba, 8'h80);
        smp = 12'h0aa;
        repeat (3) @(negedge core_clk_i);
        cmp(power_on_o, 1'b0);
        nstart = 0;
        nfirst = 0;
        start_conv();
        for (k = 0; k < 200 && conv_start_o !== 1'b1; k++)
            @(negedge core_clk_i);
        cmp(16'(k >= 11 && k <= 16), 16'h1);
        wait_done();
        repeat (3) @(negedge core_clk_i);
        cmp(power_on_o, 1'b0);
        chk_res(16'h00aa);
        cmp(16'(nstart), 16'h1);
        cmp(16'(nfirst), 16'h1);
        summarize();
    end
endmodule
`default_nettype wire
